// [watchdog_and_reset_key_control_bench.sv]
// Self-checking bench for the watchdog and reset-key block
`timescale 1ns/1ps
`default_nettype none
`include "wdk_defines.svh"
module watchdog_and_reset_key_control_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0;
  logic slow_run = 1'b0;
  logic lv = 1'b0;
  logic lvk = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, dev_rst, pcsp, wake, irq, clr, halt, sleep;
  logic [32:0] exp_q[$];
  logic [7:0] n_rst = 8'h0;
  logic [7:0] n_pcsp = 8'h0;
  logic [7:0] n_wake = 8'h0;
  logic [1:0] m;
  logic [7:0] r0;
  int err_count = 0;
  int samples_checked = 0;
  integer seed = 32'ha3614c80;
  // ----------------------------------------------------------------
  // Clocks, design and partner
  // ----------------------------------------------------------------
  always #25 clk_i = ~clk_i;
  // Slow oscillator, one tick every two cycles
  always @(posedge clk_i) begin
    if (slow_run) begin
      slow <= ~slow;
    end
  end
  wdk_top #(.ADDR_W(12), .SRST_TICKS(16'h0002)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .slow_osc_clock_i(slow), .clear_watchdog_instr_i(clr), .halt_i(halt), .sleep_i(sleep),
    .lowvolt_reset_i(lv), .lowvolt_key_reset_i(lvk), .device_reset_o(dev_rst),
    .pc_sp_reset_o(pcsp), .wake_o(wake), .irq_o(irq)
  );
  wdk_cpu_model cpu (
    .clk_i(clk_i), .wake_i(wake), .clear_watchdog_instr_o(clr), .halt_o(halt), .sleep_o(sleep)
  );
  // ----------------------------------------------------------------
  // Compare, report and bus tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t read got %h exp %h", $time, got, exp);
    end
  endtask : cmp_rd
  task automatic cmp_ev(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t event count got %h exp %h", $time, got, exp);
    end
  endtask : cmp_ev
  // APB master: hold the request until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int n;
    if (!wr) begin
      exp_q.push_back(exp);
    end
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("[ERR] %0t no bus answer", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0, exp);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  // Overflow must not come early, and must come on time
  task automatic ovf_check(input int ticks, input logic nap);
    logic [7:0] a0, p0, w0;
    a0 = n_rst;
    p0 = n_pcsp;
    w0 = n_wake;
    cpu.instr(nap, nap);
    repeat (2 * ticks - 16) @(posedge clk_i);
    cmp_ev(n_rst + n_pcsp, a0 + p0);
    repeat (32) @(posedge clk_i);
    cmp_ev(n_rst, a0 + {7'h0, ~nap});
    cmp_ev(n_pcsp, p0 + {7'h0, nap});
    cmp_ev(n_wake, w0 + {7'h0, nap});
  endtask : ovf_check
  // ----------------------------------------------------------------
  // Result watcher: read data against the oldest note, pulse counts
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      cmp_rd({pslverr, prdata}, exp_q.pop_front());
    end
    if (dev_rst === 1'b1) begin
      n_rst <= n_rst + 8'h1;
    end
    if (pcsp === 1'b1) begin
      n_pcsp <= n_pcsp + 8'h1;
    end
    if (wake === 1'b1) begin
      n_wake <= n_wake + 8'h1;
    end
  end
  // Watchdog against a hang
  initial begin
    #2000000;
    err_count++;
    results();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`WDK_OFF_WDC, 33'h53);
    rd(`WDK_OFF_RKR, 33'h55);
    rd(`WDK_OFF_RCF, 33'h0);
    rd(12'h040, {1'b1, 32'h0});
    wr(`WDK_OFF_IMSK, 32'h1);
    wr(`WDK_OFF_WDC, 32'h50);
    slow_run <= 1'b1;
    ovf_check(256, 1'b0);
    rd(`WDK_OFF_STAT, 33'h1);
    cmp_ev({7'h0, irq}, 8'h1);
    wr(`WDK_OFF_IST, 32'h3);
    @(posedge clk_i);
    cmp_ev({7'h0, irq}, 8'h0);
    wr(`WDK_OFF_WDC, 32'h51);
    ovf_check(1024, 1'b0);
    wr(`WDK_OFF_WDC, 32'h52);
    ovf_check(4096, 1'b0);
    wr(`WDK_OFF_WDC, 32'h50);
    ovf_check(256, 1'b1);
    rd(`WDK_OFF_STAT, 33'h3);
    // Status is read-only: a write leaves it as it was
    wr(`WDK_OFF_STAT, 32'h0);
    rd(`WDK_OFF_STAT, 33'h3);
    // Regular clears hold off the overflow
    r0 = n_rst;
    repeat (6) begin
      cpu.instr(1'b0, 1'b0);
      repeat (400) @(posedge clk_i);
    end
    cmp_ev(n_rst, r0);
    // Disable key stops the watchdog
    wr(`WDK_OFF_WDC, 32'ha8);
    repeat (1200) @(posedge clk_i);
    cmp_ev(n_rst, r0);
    // Random mask against pending overflow event
    m = 2'($random(seed));
    wr(`WDK_OFF_IMSK, {30'h0, m});
    rd(`WDK_OFF_IMSK, {31'h0, m});
    cmp_ev({7'h0, irq}, {7'h0, m[0]});
    wr(`WDK_OFF_IST, 32'h3);
    // Bad watchdog key, then bad reset key
    for (int i = 0; i < 2; i++) begin
      r0 = n_rst;
      wr(i ? `WDK_OFF_RKR : `WDK_OFF_WDC, i ? 32'h12 : 32'hf8);
      repeat (40) @(posedge clk_i);
      cmp_ev(n_rst, r0 + 8'h1);
      rd(`WDK_OFF_WDC, 33'h53);
      rd(`WDK_OFF_RKR, 33'h55);
      rd(`WDK_OFF_RCF, i ? 33'h8 : 33'h1);
      wr(`WDK_OFF_RCF, 32'hf);
      rd(`WDK_OFF_RCF, i ? 33'h8 : 33'h1);
      wr(`WDK_OFF_RCF, 32'h0);
      rd(`WDK_OFF_RCF, 33'h0);
    end
    // Low-voltage flag inputs
    @(posedge clk_i);
    lv <= 1'b1;
    lvk <= 1'b1;
    @(posedge clk_i);
    lv <= 1'b0;
    lvk <= 1'b0;
    rd(`WDK_OFF_RCF, 33'h6);
    results();
  end
endmodule : watchdog_and_reset_key_control_bench
`default_nettype wire

// [wdk_cpu_model.sv]
// CPU core model: instruction pulses and sleep state
`timescale 1ns/1ps
`default_nettype none
module wdk_cpu_model (
  input wire logic clk_i,
  input wire logic wake_i,
  output logic clear_watchdog_instr_o,
  output logic halt_o,
  output logic sleep_o
);
  // ----------------------------------------------------------------
  // Instruction issue
  // ----------------------------------------------------------------
  // Idle at time zero
  initial begin
    clear_watchdog_instr_o = 1'b0;
    halt_o = 1'b0;
    sleep_o = 1'b0;
  end
  // One-cycle pulse; a halt may also enter sleep
  task automatic instr(input logic is_halt, input logic nap);
    @(posedge clk_i);
    clear_watchdog_instr_o <= ~is_halt;
    halt_o <= is_halt;
    sleep_o <= nap;
    @(posedge clk_i);
    clear_watchdog_instr_o <= 1'b0;
    halt_o <= 1'b0;
  endtask : instr
  // Wake pulse ends sleep
  always @(posedge clk_i) begin
    if (wake_i === 1'b1) begin
      sleep_o <= 1'b0;
    end
  end
endmodule : wdk_cpu_model
`default_nettype wire

// [wdk_defines.svh]
// Constant names for the watchdog and reset-key control block
`ifndef WDK_DEFINES_SVH
`define WDK_DEFINES_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WDK_OFF_WDC 12'h000
`define WDK_OFF_RCF 12'h004
`define WDK_OFF_RKR 12'h008
`define WDK_OFF_STAT 12'h00c
`define WDK_OFF_IST 12'h010
`define WDK_OFF_IMSK 12'h014
// ----------------------------------------------------------------
// Decode hit positions
// ----------------------------------------------------------------
`define WDK_H_WDC 0
`define WDK_H_RCF 1
`define WDK_H_RKR 2
`define WDK_H_STAT 3
`define WDK_H_IST 4
`define WDK_H_IMSK 5
`define WDK_H_NUM 6
// ----------------------------------------------------------------
// Reset values and key codes
// ----------------------------------------------------------------
`define WDK_WDC_RST 8'h53
`define WDK_RKR_RST 8'h55
`define WDK_RKR_OK_A 8'h55
`define WDK_RKR_OK_B 8'haa
`define WDK_KEY_EN 5'h0a
`define WDK_KEY_DIS 5'h15
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WDK_KEY_MSB 7
`define WDK_KEY_LSB 3
`define WDK_SEL_MSB 2
`define WDK_RCF_WK 0
`define WDK_RCF_LK 1
`define WDK_RCF_LV 2
`define WDK_RCF_RK 3
`define WDK_RCF_W 4
`define WDK_ST_TO 0
`define WDK_ST_PD 1
`define WDK_EV_TO 0
`define WDK_EV_SR 1
`define WDK_EV_W 2
// ----------------------------------------------------------------
// Counter sizing and timeout shifts
// ----------------------------------------------------------------
`define WDK_CNT_W 18
`define WDK_SRST_CW 16
`define WDK_SRST_TICKS 16
`define WDK_SH_0 8
`define WDK_SH_1 10
`define WDK_SH_2 12
`define WDK_SH_3 14
`define WDK_SH_4 15
`define WDK_SH_5 16
`define WDK_SH_6 17
`define WDK_SH_7 18
`endif

// [wdk_link_if.sv]
// Internal link between the control top, the counter and the reset delay
`timescale 1ns/1ps
`default_nettype none
interface wdk_link_if;
  logic tick;
  logic wd_en;
  logic wd_clr;
  logic [2:0] sel;
  logic ovf;
  logic srst_start;
  logic srst_busy;
  logic srst_done;
  modport ctl (output wd_en, wd_clr, sel, srst_start, input tick, ovf, srst_busy, srst_done);
  modport wd (input wd_en, wd_clr, sel, output tick, ovf);
  modport srst (input tick, srst_start, output srst_busy, srst_done);
endinterface : wdk_link_if
`default_nettype wire

// [wdk_pkg.sv]
// Types shared by the watchdog and reset-key control block
`default_nettype none
`include "wdk_defines.svh"
package wdk_pkg;
  typedef enum logic {wdk_srst_idle, wdk_srst_wait} wdk_srst_e;

  typedef struct packed {
    wdk_srst_e st;
    logic [`WDK_SRST_CW-1:0] cnt;
    logic done;
  } wdk_srst_s;

  typedef struct packed {
    logic osc_q;
    logic tick;
    logic [`WDK_CNT_W-1:0] cnt;
    logic ovf;
  } wdk_wd_s;

  typedef struct packed {
    logic [7:0] wdc;
    logic [`WDK_RCF_W-1:0] rcf;
    logic [7:0] rkr;
    logic to;
    logic pd;
    logic [`WDK_EV_W-1:0] ist;
    logic [`WDK_EV_W-1:0] imsk;
    logic pend_wk;
    logic pend_rk;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dev_rst;
    logic pcsp;
    logic wake;
    logic irq;
  } wdk_top_s;
endpackage : wdk_pkg
`default_nettype wire

// [wdk_soft_reset_delay.sv]
// Delay from a bad key to the device reset, counted in slow ticks
`timescale 1ns/1ps
`default_nettype none
module wdk_soft_reset_delay #(
  parameter logic [`WDK_SRST_CW-1:0] DELAY_TICKS = `WDK_SRST_CW'(`WDK_SRST_TICKS)
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  wdk_link_if.srst lnk
);
  wdk_pkg::wdk_srst_s s_reg;
  wdk_pkg::wdk_srst_s s_next;

  // Idle until started, then wait out the ticks
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      wdk_pkg::wdk_srst_idle: begin
        if (lnk.srst_start) begin
          s_next.st = wdk_pkg::wdk_srst_wait;
          s_next.cnt = '0;
        end
      end
      default: begin
        if (lnk.tick) begin
          if (s_reg.cnt >= DELAY_TICKS - `WDK_SRST_CW'(1)) begin
            s_next.done = 1'b1;
            s_next.st = wdk_pkg::wdk_srst_idle;
          end else begin
            s_next.cnt = s_reg.cnt + `WDK_SRST_CW'(1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg <= '{st: wdk_pkg::wdk_srst_idle, cnt: '0, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.srst_busy = (s_reg.st == wdk_pkg::wdk_srst_wait);
  assign lnk.srst_done = s_reg.done;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_delay;
    s_reg.done |-> $past(s_reg.cnt) == DELAY_TICKS - `WDK_SRST_CW'(1) && $past(lnk.tick);
  endproperty
  a_delay: assert property (p_delay) else $error("reset delay wrong");
endmodule : wdk_soft_reset_delay
`default_nettype wire

// [wdk_top.sv]
// Watchdog, reset-key control and reset-cause flags behind an APB slave
`timescale 1ns/1ps
`default_nettype none
module wdk_top #(
  parameter int ADDR_W = 12,
  parameter logic [`WDK_SRST_CW-1:0] SRST_TICKS = `WDK_SRST_CW'(`WDK_SRST_TICKS)
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic slow_osc_clock_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic halt_i,
  input wire logic sleep_i,
  input wire logic lowvolt_reset_i,
  input wire logic lowvolt_key_reset_i,
  output logic device_reset_o,
  output logic pc_sp_reset_o,
  output logic wake_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // State and sub-blocks
  // ----------------------------------------------------------------
  wdk_pkg::wdk_top_s s_reg;
  wdk_pkg::wdk_top_s s_next;
  wdk_link_if lnk ();
  logic [`WDK_H_NUM-1:0] hit;
  logic wr;
  logic setup;
  logic wk_bad_now;
  logic rk_bad_now;
  logic [31:0] rdata;

  wdk_watchdog_counter u_cnt (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .slow_osc_clock_i(slow_osc_clock_i),
    .lnk(lnk.wd)
  );

  wdk_soft_reset_delay #(
    .DELAY_TICKS(SRST_TICKS)
  ) u_srst (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .lnk(lnk.srst)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One-hot register decode, zero for an unmapped address
  function automatic logic [`WDK_H_NUM-1:0] addr_dec(input logic [ADDR_W-1:0] a);
    logic [11:0] w;
    w = 12'(a);
    addr_dec = '0;
    if (ADDR_W > 12 && (a >> 12) != '0) begin
      addr_dec = '0;
    end else if (w == `WDK_OFF_WDC) begin
      addr_dec[`WDK_H_WDC] = 1'b1;
    end else if (w == `WDK_OFF_RCF) begin
      addr_dec[`WDK_H_RCF] = 1'b1;
    end else if (w == `WDK_OFF_RKR) begin
      addr_dec[`WDK_H_RKR] = 1'b1;
    end else if (w == `WDK_OFF_STAT) begin
      addr_dec[`WDK_H_STAT] = 1'b1;
    end else if (w == `WDK_OFF_IST) begin
      addr_dec[`WDK_H_IST] = 1'b1;
    end else if (w == `WDK_OFF_IMSK) begin
      addr_dec[`WDK_H_IMSK] = 1'b1;
    end
  endfunction : addr_dec

  // Watchdog key holds neither the enable nor the disable code
  function automatic logic wk_bad(input logic [7:0] wdc);
    wk_bad = (wdc[`WDK_KEY_MSB:`WDK_KEY_LSB] != `WDK_KEY_EN) &&
             (wdc[`WDK_KEY_MSB:`WDK_KEY_LSB] != `WDK_KEY_DIS);
  endfunction : wk_bad

  // Reset key holds neither of the two quiet codes
  function automatic logic rk_bad(input logic [7:0] rkr);
    rk_bad = (rkr != `WDK_RKR_OK_A) && (rkr != `WDK_RKR_OK_B);
  endfunction : rk_bad

  // ----------------------------------------------------------------
  // Links to the counter and the reset delay
  // ----------------------------------------------------------------
  // Key decode steers the counter
  assign wk_bad_now = wk_bad(s_reg.wdc);
  assign rk_bad_now = rk_bad(s_reg.rkr);
  assign lnk.wd_en = (s_reg.wdc[`WDK_KEY_MSB:`WDK_KEY_LSB] == `WDK_KEY_EN);
  assign lnk.sel = s_reg.wdc[`WDK_SEL_MSB:0];
  // Clear and halt are single pulses; a bad watchdog key holds the count at zero
  assign lnk.wd_clr = clear_watchdog_instr_i | halt_i | wk_bad_now;
  // Start the delay once per bad key episode
  assign lnk.srst_start = (wk_bad_now | rk_bad_now) & ~lnk.srst_busy & ~lnk.srst_done;

  // ----------------------------------------------------------------
  // APB decode and read mux
  // ----------------------------------------------------------------
  assign hit = addr_dec(paddr_i);
  assign setup = psel_i & ~penable_i;
  assign wr = psel_i & penable_i & pwrite_i & s_reg.pready & pstrb_i[0];

  // Read data, narrow registers in the low bits
  always_comb begin
    rdata = '0;
    if (hit[`WDK_H_WDC]) begin
      rdata[7:0] = s_reg.wdc;
    end else if (hit[`WDK_H_RCF]) begin
      rdata[`WDK_RCF_W-1:0] = s_reg.rcf;
    end else if (hit[`WDK_H_RKR]) begin
      rdata[7:0] = s_reg.rkr;
    end else if (hit[`WDK_H_STAT]) begin
      rdata[`WDK_ST_TO] = s_reg.to;
      rdata[`WDK_ST_PD] = s_reg.pd;
    end else if (hit[`WDK_H_IST]) begin
      rdata[`WDK_EV_W-1:0] = s_reg.ist;
    end else if (hit[`WDK_H_IMSK]) begin
      rdata[`WDK_EV_W-1:0] = s_reg.imsk;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Bus answer: data sampled in setup, ready in the access cycle
    s_next.pready = setup;
    if (setup) begin
      s_next.prdata = rdata;
      s_next.pslverr = (hit == '0);
    end
    // Output pulses default low
    s_next.dev_rst = 1'b0;
    s_next.pcsp = 1'b0;
    s_next.wake = 1'b0;

    // Software writes; clears come first so hardware sets win
    if (wr && hit[`WDK_H_WDC]) begin
      s_next.wdc = pwdata_i[7:0];
    end
    if (wr && hit[`WDK_H_RKR]) begin
      s_next.rkr = pwdata_i[7:0];
    end
    if (wr && hit[`WDK_H_RCF]) begin
      s_next.rcf = s_reg.rcf & pwdata_i[`WDK_RCF_W-1:0];
    end
    if (wr && hit[`WDK_H_IST]) begin
      s_next.ist = s_reg.ist & ~pwdata_i[`WDK_EV_W-1:0];
    end
    if (wr && hit[`WDK_H_IMSK]) begin
      s_next.imsk = pwdata_i[`WDK_EV_W-1:0];
    end

    // Remember which key caused the pending reset
    s_next.pend_wk = s_reg.pend_wk | wk_bad_now;
    s_next.pend_rk = s_reg.pend_rk | rk_bad_now;

    // Halt enters power-down and clears timeout; clear instruction leaves it
    if (halt_i) begin
      s_next.to = 1'b0;
    end
    if (clear_watchdog_instr_i) begin
      s_next.pd = 1'b0;
    end
    if (halt_i) begin
      s_next.pd = 1'b1;
    end

    // Overflow: full reset when running, wake with PC and SP reset in sleep
    if (lnk.ovf) begin
      s_next.to = 1'b1;
      s_next.ist[`WDK_EV_TO] = 1'b1;
      if (sleep_i) begin
        s_next.pcsp = 1'b1;
        s_next.wake = 1'b1;
      end else begin
        s_next.dev_rst = 1'b1;
      end
    end

    // Delay elapsed: reset device, record cause, restore the keys
    if (lnk.srst_done) begin
      s_next.dev_rst = 1'b1;
      s_next.rcf[`WDK_RCF_WK] = s_reg.pend_wk | s_next.rcf[`WDK_RCF_WK];
      s_next.rcf[`WDK_RCF_RK] = s_reg.pend_rk | s_next.rcf[`WDK_RCF_RK];
      s_next.wdc = `WDK_WDC_RST;
      s_next.rkr = `WDK_RKR_RST;
      s_next.pend_wk = 1'b0;
      s_next.pend_rk = 1'b0;
      s_next.ist[`WDK_EV_SR] = 1'b1;
    end

    // Low-voltage causes are only recorded here
    if (lowvolt_reset_i) begin
      s_next.rcf[`WDK_RCF_LV] = 1'b1;
    end
    if (lowvolt_key_reset_i) begin
      s_next.rcf[`WDK_RCF_LK] = 1'b1;
    end

    // Level interrupt from unmasked sticky events
    s_next.irq = |(s_next.ist & s_next.imsk);
  end

  // State register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg <= '{wdc: `WDK_WDC_RST, rkr: `WDK_RKR_RST, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o = s_reg.prdata;
  assign pready_o = s_reg.pready;
  assign pslverr_o = s_reg.pslverr;
  assign device_reset_o = s_reg.dev_rst;
  assign pc_sp_reset_o = s_reg.pcsp;
  assign wake_o = s_reg.wake;
  assign irq_o = s_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_key_dis;
    s_reg.wdc[`WDK_KEY_MSB:`WDK_KEY_LSB] == `WDK_KEY_DIS |-> !lnk.wd_en && !wk_bad_now;
  endproperty
  a_key_dis: assert property (p_key_dis) else $error("disable key misread");
  property p_wk_start;
    wk_bad_now && !lnk.srst_busy && !lnk.srst_done |=> lnk.srst_busy && s_reg.pend_wk;
  endproperty
  a_wk_start: assert property (p_wk_start) else $error("bad key did not start delay");
  property p_wrf_set;
    lnk.srst_done && s_reg.pend_wk |=> s_reg.rcf[`WDK_RCF_WK] && device_reset_o;
  endproperty
  a_wrf_set: assert property (p_wrf_set) else $error("key flag not set");
  property p_wrf_keep;
    s_reg.rcf[`WDK_RCF_WK] && !(wr && hit[`WDK_H_RCF]) |=> s_reg.rcf[`WDK_RCF_WK];
  endproperty
  a_wrf_keep: assert property (p_wrf_keep) else $error("key flag lost");
  property p_rk_start;
    rk_bad_now && !lnk.srst_busy && !lnk.srst_done |-> lnk.srst_start;
  endproperty
  a_rk_start: assert property (p_rk_start) else $error("bad reset key ignored");
  property p_reload;
    lnk.srst_done |=> s_reg.wdc == `WDK_WDC_RST && s_reg.rkr == `WDK_RKR_RST;
  endproperty
  a_reload: assert property (p_reload) else $error("keys not restored");
  property p_rkf_set;
    lnk.srst_done && s_reg.pend_rk |=> s_reg.rcf[`WDK_RCF_RK] ##1
      (s_reg.rcf[`WDK_RCF_RK] || $past(wr && hit[`WDK_H_RCF]));
  endproperty
  a_rkf_set: assert property (p_rkf_set) else $error("reset key flag not set");
  property p_upper;
    setup && hit[`WDK_H_RCF] |=> prdata_o[31:`WDK_RCF_W] == '0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper flag bits not zero");
  property p_ovf_run;
    lnk.ovf && !sleep_i |=> device_reset_o && s_reg.to && !wake_o && !pc_sp_reset_o;
  endproperty
  a_ovf_run: assert property (p_ovf_run) else $error("running overflow wrong");
  property p_ovf_sleep;
    lnk.ovf && sleep_i |=> pc_sp_reset_o && wake_o && s_reg.to && !device_reset_o;
  endproperty
  a_ovf_sleep: assert property (p_ovf_sleep) else $error("sleep overflow wrong");
  property p_clr;
    clear_watchdog_instr_i || halt_i |-> lnk.wd_clr ##1 !lnk.ovf;
  endproperty
  a_clr: assert property (p_clr) else $error("clear not passed on");
  // Bus timing, flag and key upkeep
  property p_ready;
    setup |=> pready_o ##1 !pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
  property p_irq;
    |(s_reg.ist & s_reg.imsk) |-> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked event without interrupt");
  property p_halt_pd;
    halt_i && !lnk.ovf |=> s_reg.pd && !s_reg.to;
  endproperty
  a_halt_pd: assert property (p_halt_pd) else $error("halt flags wrong");
  property p_wk_clr;
    wk_bad_now |-> lnk.wd_clr;
  endproperty
  a_wk_clr: assert property (p_wk_clr) else $error("bad key did not clear count");
  property p_done_rst;
    lnk.srst_done |=> device_reset_o;
  endproperty
  a_done_rst: assert property (p_done_rst) else $error("delay end without reset");
  property p_rkf_keep;
    s_reg.rcf[`WDK_RCF_RK] && !(wr && hit[`WDK_H_RCF]) |=> s_reg.rcf[`WDK_RCF_RK];
  endproperty
  a_rkf_keep: assert property (p_rkf_keep) else $error("reset key flag lost");
  property p_rcf_clr;
    wr && hit[`WDK_H_RCF] && !lnk.srst_done && !lowvolt_reset_i && !lowvolt_key_reset_i
      |=> s_reg.rcf == ($past(s_reg.rcf) & $past(pwdata_i[`WDK_RCF_W-1:0]));
  endproperty
  a_rcf_clr: assert property (p_rcf_clr) else $error("flag write wrong");
  property p_wdc_wr;
    wr && hit[`WDK_H_WDC] && !lnk.srst_done |=> s_reg.wdc == $past(pwdata_i[7:0]);
  endproperty
  a_wdc_wr: assert property (p_wdc_wr) else $error("control write lost");
  property p_rkr_wr;
    wr && hit[`WDK_H_RKR] && !lnk.srst_done |=> s_reg.rkr == $past(pwdata_i[7:0]);
  endproperty
  a_rkr_wr: assert property (p_rkr_wr) else $error("reset key write lost");
  property p_en_key;
    s_reg.wdc[`WDK_KEY_MSB:`WDK_KEY_LSB] == `WDK_KEY_EN |-> lnk.wd_en && !wk_bad_now;
  endproperty
  a_en_key: assert property (p_en_key) else $error("enable key misread");
endmodule : wdk_top
`default_nettype wire

// [wdk_watchdog_counter.sv]
// Slow-clock edge detect and watchdog overflow counter
`timescale 1ns/1ps
`default_nettype none
module wdk_watchdog_counter (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic slow_osc_clock_i,
  wdk_link_if.wd lnk
);
  wdk_pkg::wdk_wd_s s_reg;
  wdk_pkg::wdk_wd_s s_next;
  logic tick_now;

  // Last count value for a timeout select
  function automatic logic [`WDK_CNT_W-1:0] last_count(input logic [2:0] sel);
    int sh;
    case (sel)
      3'h0: sh = `WDK_SH_0;
      3'h1: sh = `WDK_SH_1;
      3'h2: sh = `WDK_SH_2;
      3'h3: sh = `WDK_SH_3;
      3'h4: sh = `WDK_SH_4;
      3'h5: sh = `WDK_SH_5;
      3'h6: sh = `WDK_SH_6;
      default: sh = `WDK_SH_7;
    endcase
    last_count = `WDK_CNT_W'((64'h1 << sh) - 64'h1);
  endfunction : last_count

  // Rising edge of the slow oscillator, then count
  always_comb begin
    s_next = s_reg;
    tick_now = slow_osc_clock_i & ~s_reg.osc_q;
    s_next.osc_q = slow_osc_clock_i;
    s_next.tick = tick_now;
    s_next.ovf = 1'b0;
    if (lnk.wd_clr) begin
      s_next.cnt = '0;
    end else if (lnk.wd_en && tick_now) begin
      if (s_reg.cnt >= last_count(lnk.sel)) begin
        s_next.cnt = '0;
        s_next.ovf = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + `WDK_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.tick = s_reg.tick;
  assign lnk.ovf = s_reg.ovf;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_clear;
    lnk.wd_clr |=> s_reg.cnt == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");
  property p_period;
    s_reg.ovf |-> $past(s_reg.cnt) >= last_count($past(lnk.sel));
  endproperty
  a_period: assert property (p_period) else $error("early overflow");
  property p_hold;
    !lnk.wd_en && !lnk.wd_clr |=> $stable(s_reg.cnt) && !s_reg.ovf;
  endproperty
  a_hold: assert property (p_hold) else $error("disabled count moved");
endmodule : wdk_watchdog_counter
`default_nettype wire
